// File: hdl/sdf_cfg.svh
// Constants for the delta-sigma sinc decimator
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH
`define SDF_SYS_CLK_MHZ 100
`define SDF_MOD_CLK_MHZ 20
`define SDF_MOD_DIV (`SDF_SYS_CLK_MHZ / `SDF_MOD_CLK_MHZ)
`define SDF_MOD_HALF (`SDF_MOD_DIV / 2)
`define SDF_ORDER 3
`define SDF_DECIM 256
`define SDF_DIFF_DELAY 1
`define SDF_FIFO_DEPTH 8
`endif

// File: hdl/sdf_pkg.sv
// Types for the delta-sigma sinc decimator
package sdf_pkg;
	typedef struct packed {
		logic overRange;
		logic [31:0] value;
	} sdf_sample_t;
endpackage : sdf_pkg

// File: hdl/sdf_fifo.sv
// Kept empty: the sample FIFO module sits beside the decimator logic

// File: hdl/sdf_decimator.sv
// Sinc (CIC) decimator for a delta-sigma modulator bitstream
`timescale 1ns/1ns
`default_nettype none
`include "sdf_cfg.svh"
// Behaviour
// RQ1: Link is a bit line plus a clock line that this block drives.
// RQ2: One modulator bit is taken per modulator clock cycle.
// RQ3: Modulator changes its bit only on the falling clock edge.
// RQ4: Modulator clock runs at 20 MHz; one bit filtered per cycle.
// RQ5: Ones density tracks input; filter recovers it by averaging.
// RQ6: Zero input gives ones half the time, mid-scale output.
// RQ7: Full scale gives 90 or 10 percent ones.
// RQ8: Beyond absolute full scale the stream is all ones or zeros.
// RQ9: Filter uses only adders, subtractors and delay registers.
// RQ10: N integrator stages run at the full bit rate.
// RQ11: Order and decimation are parameters; third order by default.
// RQ12: Each integrator adds its input to its previous output.
// RQ13: Every R-th integrator sample feeds N comb stages at low rate.
// RQ14: Comb output is input minus input M samples ago; M is 1 or 2.
// RQ15: Bit is sampled at the rising modulator clock edge.
// RQ16: Wrap-around two's-complement registers sized for exact output.
module sdf_decimator #(
	parameter int ORDER = `SDF_ORDER,
	parameter int DECIM = `SDF_DECIM,
	parameter int DIFF_DELAY = `SDF_DIFF_DELAY,
	parameter int FIFO_DEPTH = `SDF_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Modulator link
	output logic modulatorClockOut,
	input wire logic modulatorData,
	// Sample stream
	output logic sampleValid,
	input wire logic sampleReady,
	output sdf_pkg::sdf_sample_t sample
);
	// Growth is N*log2(R*M); a signed +1/-1 input needs two bits, else +full scale wraps
	localparam int ACC_W = ORDER * $clog2(DECIM * DIFF_DELAY) + 2;
	localparam int OUT_W = 32;
	localparam int DIV_W = 4;
	localparam int DEC_W = $clog2(DECIM) + 1;

	logic [DIV_W-1:0] divCount;
	logic [1:0] dataSync;
	logic [1:0] clockSync;
	logic clockSeen;
	logic bitStrobe;
	logic [ACC_W-1:0] integ [ORDER];
	logic [ACC_W-1:0] combIn [ORDER+1];
	logic [ACC_W-1:0] combHist [ORDER][DIFF_DELAY];
	logic [DEC_W-1:0] decCount;
	logic decStrobe;
	logic combValid;
	logic [ACC_W-1:0] combOut;
	logic allSame;
	logic onesRun;
	logic fifoReady;
	sdf_pkg::sdf_sample_t fifoIn;
	logic [ACC_W-1:0] integInput;

	// Modulator clock divided from the system clock, high three of five cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divCount <= '0;
			modulatorClockOut <= 1'b0;
		end else if (divCount == DIV_W'(`SDF_MOD_DIV - 1)) begin
			divCount <= '0;
			modulatorClockOut <= 1'b0;
		end else begin
			divCount <= divCount + 1'b1;
			if (divCount == DIV_W'(`SDF_MOD_HALF - 1)) begin
				modulatorClockOut <= 1'b1; // RQ1 RQ4
			end
		end
	end

	// Pin and clock echo pass two flops; the bit settles after the falling edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dataSync <= '0;
			clockSync <= '0;
			clockSeen <= 1'b0;
		end else begin
			dataSync <= {dataSync[0], modulatorData};
			clockSync <= {clockSync[0], modulatorClockOut};
			clockSeen <= clockSync[1];
		end
	end

	// One bit per rising modulator clock edge, delayed equally to the data
	assign bitStrobe = clockSync[1] && !clockSeen; // RQ2 RQ3 RQ15

	// Bit mapped to +1/-1 so zero input averages to zero
	assign integInput = dataSync[1] ? ACC_W'(1) : {ACC_W{1'b1}}; // RQ5 RQ6

	genvar g;
	generate
		for (g = 0; g < ORDER; g++) begin : gInteg
			logic [ACC_W-1:0] stageIn;
			// First stage takes the bit; no out-of-range index for stage zero
			if (g == 0) begin : gFirst
				assign stageIn = integInput;
			end else begin : gNext
				assign stageIn = integ[g-1];
			end
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					integ[g] <= '0;
				end else if (bitStrobe) begin
					integ[g] <= integ[g] + stageIn; // RQ9 RQ10 RQ12 RQ16
				end
			end
		end
	endgenerate

	// Decimation counter in bit cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			decCount <= '0;
			decStrobe <= 1'b0;
			allSame <= 1'b1;
			onesRun <= 1'b0;
		end else begin
			decStrobe <= 1'b0;
			if (bitStrobe) begin
				if (decCount == DEC_W'(DECIM - 1)) begin
					decCount <= '0;
					decStrobe <= 1'b1; // RQ13
				end else begin
					decCount <= decCount + 1'b1;
				end
				// Clipping check: a frame of identical bits
				if (decCount == '0) begin
					allSame <= 1'b1;
					onesRun <= dataSync[1];
				end else if (dataSync[1] != onesRun) begin
					allSame <= 1'b0;
				end
			end
		end
	end

	assign combIn[0] = integ[ORDER-1];

	generate
		for (g = 0; g < ORDER; g++) begin : gComb
			assign combIn[g+1] = combIn[g] - combHist[g][DIFF_DELAY-1]; // RQ14 RQ16
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					for (int k = 0; k < DIFF_DELAY; k++) begin
						combHist[g][k] <= '0;
					end
				end else if (decStrobe) begin
					combHist[g][0] <= combIn[g];
					for (int k = 1; k < DIFF_DELAY; k++) begin
						combHist[g][k] <= combHist[g][k-1];
					end
				end
			end
		end
	endgenerate

	// Comb chain is combinational; one register at the low rate
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			combOut <= '0;
			combValid <= 1'b0;
		end else begin
			combValid <= decStrobe && fifoReady;
			if (decStrobe) begin
				combOut <= combIn[ORDER]; // RQ11 RQ13
			end
		end
	end

	// Full frame of one bit value marks a clipped input
	assign fifoIn.overRange = allSame; // RQ7 RQ8
	assign fifoIn.value = OUT_W'($signed(combOut));

	sdf_fifo #(
		.WIDTH($bits(sdf_pkg::sdf_sample_t)),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.clock(clock),
		.rst_n(rst_n),
		.inValid(combValid),
		.inReady(fifoReady),
		.inData(fifoIn),
		.outValid(sampleValid),
		.outReady(sampleReady),
		.outData(sample)
	);
endmodule : sdf_decimator

// Sample FIFO with valid/ready on both sides
module sdf_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Write side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Read side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic doWrite;
	logic doRead;

	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			inReady <= 1'b1;
			outValid <= 1'b0;
		end else begin
			if (doWrite) begin
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			end
			if (doRead) begin
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
			inReady <= (count + (AW+1)'(doWrite) - (AW+1)'(doRead)) != (AW+1)'(DEPTH);
			outValid <= (count + (AW+1)'(doWrite) - (AW+1)'(doRead)) != '0;
		end
	end

	always_ff @(posedge clock) begin
		if (doWrite) begin
			mem[wrPtr] <= inData;
		end
	end

	// Registered output; with one entry left the head is the just-written word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			outData <= '0;
		end else if (doRead && count > 1) begin
			outData <= mem[(rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1];
		end else if (doWrite && (count == 0 || (doRead && count == 1))) begin
			outData <= inData;
		end
	end
endmodule : sdf_fifo
`default_nettype wire

// File: test/sdf_decimator_properties.sv
// Port checks for the sinc decimator
`timescale 1ns/1ns
`default_nettype none
module sdf_decimator_properties #(
	parameter int ORDER = 3,
	parameter int DECIM = 256,
	parameter int DIFF_DELAY = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link and stream
	input wire logic modulatorClockOut,
	input wire logic modulatorData,
	input wire logic sampleValid,
	input wire logic sampleReady,
	input wire sdf_pkg::sdf_sample_t sample
);
	localparam int GAIN = (DECIM * DIFF_DELAY) ** ORDER;
	logic [3:0] lowRun;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			lowRun <= 4'h0;
		else
			lowRun <= modulatorClockOut ? 4'h0 : lowRun + 4'h1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	clk_shape_a: assert property ($rose(modulatorClockOut) |->
		modulatorClockOut[*3] ##1 !modulatorClockOut[*2] ##1 modulatorClockOut) else $error("shape");
	clk_period_a: assert property ($rose(modulatorClockOut) |=>
		!$rose(modulatorClockOut)[*4] ##1 $rose(modulatorClockOut)) else $error("period");
	clk_fall_a: assert property ($fell(modulatorClockOut) |-> $past(modulatorClockOut, 2))
		else $error("short high");
	clk_gap_a: assert property (lowRun <= 4'h3)
		else $error("clock stopped");
	hold_stable_a: assert property (sampleValid && !sampleReady |=>
		sampleValid && $stable(sample)) else $error("sample not held");
	valid_fall_a: assert property ($fell(sampleValid) |-> $past(sampleReady))
		else $error("sample withdrawn");
	value_bound_a: assert property (sampleValid |->
		$signed(sample.value) <= GAIN && $signed(sample.value) >= -GAIN) else $error("range");
	reset_quiet_a: assert property ($rose(rst_n) |-> !sampleValid[*8])
		else $error("early sample");
	cover property (sampleValid && sampleReady);
	cover property (sampleValid && !sampleReady);
	cover property (sampleValid && sample.overRange);
endmodule : sdf_decimator_properties
bind sdf_decimator sdf_decimator_properties #(.ORDER(ORDER), .DECIM(DECIM),
	.DIFF_DELAY(DIFF_DELAY)) i_props (.clock(clock), .rst_n(rst_n),
	.modulatorClockOut(modulatorClockOut), .modulatorData(modulatorData),
	.sampleValid(sampleValid), .sampleReady(sampleReady), .sample(sample));
`default_nettype wire

// File: test/sdf_modulator_model.sv
// Bitstream source standing in for the modulator
`timescale 1ns/1ns
`default_nettype none
module sdf_modulator_model (
	// Link
	input wire logic modClock,
	output logic modBit,
	// Input level: 0 low clip, 1 high clip, 2 zero, 3 full scale
	input wire logic [1:0] level
);
	int phase = 0;
	initial modBit = 1'b0;
	always @(negedge modClock) begin
		phase <= (phase == 9) ? 0 : phase + 1;
		case (level)
			2'h0: modBit <= 1'b0;
			2'h1: modBit <= 1'b1;
			2'h2: modBit <= ~modBit;
			default: modBit <= (phase != 0);
		endcase
	end
endmodule : sdf_modulator_model
`default_nettype wire

// File: test/sdf_decimator_tb.sv
// Self-checking bench for the sinc decimator
`timescale 1ns/1ns
`default_nettype none
module sdf_decimator_tb;
	// Short frame keeps the run small; gain follows from it
	localparam int R = 16;
	localparam int GAIN = R * R * R;
	localparam int FRAME = R * 5;
	logic clock;
	logic rst_n;
	logic modClock;
	logic modBit;
	logic [1:0] level;
	logic [1:0] levels [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
	logic sampleValid;
	logic sampleReady;
	sdf_pkg::sdf_sample_t sample;
	sdf_pkg::sdf_sample_t got;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	logic [15:0] lfsr = 16'h30c3;
	sdf_decimator #(.DECIM(R)) i_dut (.clock(clock), .rst_n(rst_n), .modulatorClockOut(modClock),
		.modulatorData(modBit), .sampleValid(sampleValid), .sampleReady(sampleReady),
		.sample(sample));
	sdf_modulator_model i_mod (.modClock(modClock), .modBit(modBit), .level(level));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			error_cnt++;
			print_verdict();
		end
	end
	function automatic sdf_pkg::sdf_sample_t expect_sample(input logic [1:0] lv);
		sdf_pkg::sdf_sample_t e;
		e.overRange = (lv != 2'h2);
		e.value = (lv == 2'h1) ? 32'(GAIN) : (lv == 2'h0) ? -32'(GAIN) : 32'h0;
		return e;
	endfunction : expect_sample
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
		tests_run++;
		if (seen !== want) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	// Ninety percent ones averages to 0.8 of the gain; window phase moves it a little
	function automatic logic in_band(input logic [31:0] v);
		int d;
		d = $signed(v) - GAIN * 8 / 10;
		return (d <= GAIN / 20) && (d >= -(GAIN / 20));
	endfunction : in_band
	// Settled word for one input level against the ideal response
	task automatic check_level(input logic [1:0] lv);
		get_sample(got);
		if (lv == 2'h3) begin
			check("full scale band", 33'(in_band(got.value)), 33'h1);
			check("full scale flag", 33'(got.overRange), 33'h0);
		end else begin
			check("settled", got, expect_sample(lv));
		end
	endtask : check_level
	// Consumer ready is random unless stalled
	task automatic run_cycles(input int k, input logic stall);
		repeat (k) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			sampleReady = stall ? 1'b0 : lfsr[0];
			@(posedge clock);
			#1;
		end
	endtask : run_cycles
	// Flush stale words first, then take the next fresh one
	task automatic get_sample(output sdf_pkg::sdf_sample_t s);
		sampleReady = 1'b1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		for (n = 0; n < 200 && sampleValid !== 1'b1; n++) @(negedge clock);
		s = sample;
		@(posedge clock);
		#1;
	endtask : get_sample
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial begin
		rst_n = 1'b0;
		sampleReady = 1'b0;
		level = 2'h1;
		repeat (5) @(posedge clock);
		#1;
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			level = levels[i];
			run_cycles(6 * FRAME, 1'b0);
			check_level(level);
			$display("Level test %0d done", i);
		end
		level = 2'h1;
		run_cycles(6 * FRAME, 1'b0);
		check_level(level);
		// Stall ends mid-frame so no new word lands during the drain
		run_cycles(11 * FRAME + FRAME / 2, 1'b1);
		sampleReady = 1'b1;
		n = 0;
		@(negedge clock);
		while (sampleValid === 1'b1 && n < 20) begin
			check("drained", {1'b0, sample.value}, {1'b0, 32'(GAIN)});
			n++;
			@(negedge clock);
		end
		check("fifo depth", 33'(n), 33'(8));
		$display("Fill test done");
		for (int i = 0; i < 6; i++) begin
			level = lfsr[2:1];
			run_cycles(6 * FRAME, 1'b0);
			check_level(level);
		end
		$display("Random test done");
		print_verdict();
	end
endmodule : sdf_decimator_tb
`default_nettype wire
